//--- design/cal_inj_pkg.sv
// Shared constants for the calibration injection controller and pixel array
package cal_inj_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;   // ref_clk period
    localparam int STROBE_SKEW_NS = 2;   // Strobe arrival window
    // Longest time rounds down, never below one cycle
    localparam int STROBE_SKEW_CYC = (STROBE_SKEW_NS / CLK_PERIOD_NS) < 1 ?
        1 : (STROBE_SKEW_NS / CLK_PERIOD_NS);
    // ==========================================================
    // Array geometry and widths
    localparam int PIX_ROWS = 8;         // Rows in the array
    localparam int PIX_COLS = 8;         // Columns in the array
    localparam int ROW_W = 3;            // Row coordinate width
    localparam int COL_W = 3;            // Column coordinate width
    localparam int FINE_W = 3;           // Fine phase select width
    localparam int FINE_TAPS = (1 << FINE_W) - 1;  // Delay stages
    localparam int DLY_W = 8;            // Coarse delay field width
    localparam int CNT_W = DLY_W + 1;    // Sequencer counter width
    // ==========================================================
    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CMD_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_PIX_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STAT_OFS = 8'h0C;
    localparam logic [DATA_W-1:0] REG_ZERO = 32'h0;
    // Control register fields
    localparam int CTRL_DIG_BIT = 0;     // 1 = digital injection
    localparam int CTRL_ALT_BIT = 1;     // 1 = alternating assignment
    localparam int CTRL_FINE_LSB = 2;    // Fine phase select
    // Command register fields
    localparam int CMD_MODE_BIT = 0;     // 0 = step, 1 = pulse
    localparam int CMD_EDLY_LSB = 1;     // Strobe delay
    localparam int CMD_DUR_LSB = 9;      // Pulse duration
    localparam int CMD_AUXV_BIT = 17;    // Auxiliary level value
    localparam int CMD_ADLY_LSB = 18;    // Auxiliary delay
    // Pixel enable register fields
    localparam int PIX_EN_BIT = 0;
    localparam int PIX_COL_LSB = 8;
    localparam int PIX_ROW_LSB = 16;
    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_EDGE_BIT = 1;
    localparam int STAT_AUX_BIT = 2;
    // ==========================================================
    // Sequencer states
    typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;
endpackage

//--- design/cal_link_if.sv
// Distribution link from the command decoder to the pixel array
interface cal_link_if;
    import cal_inj_pkg::*;
    // ==========================================================
    // Distributed signals
    logic calStrobe;                 // Timed calibration strobe
    logic calAux;                    // Auxiliary level, loose timing
    logic digitalSel;                // 1 = digital, 0 = analog
    logic altMode;                   // Analog assignment mode
    logic [FINE_W-1:0] fineDelay;    // Global fine phase select
    logic pixWr;                     // Pixel enable write pulse
    logic [ROW_W-1:0] pixRow;        // Target row
    logic [COL_W-1:0] pixCol;        // Target column
    logic pixEn;                     // Enable value to store
    // ==========================================================
    // Decoder side drives, array side listens
    modport ctrl (output calStrobe, output calAux, output digitalSel,
        output altMode, output fineDelay, output pixWr, output pixRow,
        output pixCol, output pixEn);
    modport pix (input calStrobe, input calAux, input digitalSel,
        input altMode, input fineDelay, input pixWr, input pixRow,
        input pixCol, input pixEn);
endinterface

//--- design/cal_pixel_array.sv
// Pixel array end: per-pixel enables and injection switch generation
//
// Overview of operation
// - Digital or analog injection chosen by configuration
// - Digital injection feeds strobe straight to hits
// - Every pixel keeps its own enable bit
// - Analog injection needs enable and switch rise
// - Controller primes a switch low beforehand
// - Controller waits for settling after priming
// - One global fine delay shifts both switches
// - Strobe reaches all pixels within 2 ns
// - Uniform: first=strobe|aux, second=~strobe&aux
// - Strobe rise throws first, fall throws second
// - Aux starts low, rises after the strobe
// - Uniform order is first then second only
// - Alternating mode swaps switches on odd pixels
// - Parity is row plus column sum
// - Mode zero uniform, mode one alternating
// - Assignment independent of pixel enable bit
// - Single uniform injection holds second switch low
// - Two injections need no priming between
// - Command mode gives step or pulse strobe
// - Aux takes command value after its delay
module cal_pixel_array #(
    parameter int ROWS = cal_inj_pkg::PIX_ROWS,  // Rows in the array
    parameter int COLS = cal_inj_pkg::PIX_COLS   // Columns in the array
) (
    input wire logic ref_clk,
    input wire logic rst,
    cal_link_if.pix link,
    output logic [ROWS*COLS-1:0] firstSw,
    output logic [ROWS*COLS-1:0] secondSw,
    output logic [ROWS*COLS-1:0] analogInject,
    output logic [ROWS*COLS-1:0] digitalHit
);
    import cal_inj_pkg::*;

    // ==========================================================
    // Sizes
    localparam int NPIX = ROWS * COLS;    // Pixel count
    localparam int TAPS = FINE_TAPS;      // Fine delay stages

    // ==========================================================
    // Fine phase delay
    // Both distributed signals pass equal-depth delay chains, so the
    // strobe and the auxiliary level keep their mutual order.
    logic [TAPS-1:0] strobeDly_q;         // Strobe delay stages
    logic [TAPS-1:0] auxDly_q;            // Aux delay stages
    logic [TAPS:0] strobeTaps;            // Tap 0 is undelayed
    logic [TAPS:0] auxTaps;               // Tap 0 is undelayed
    logic calEdge;                        // Phase-shifted strobe
    logic calAuxD;                        // Phase-shifted aux level

    // Strobe delay chain
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strobeDly_q <= '0;
        end else begin
            strobeDly_q <= {strobeDly_q[TAPS-2:0], link.calStrobe};
        end
    end

    // Aux delay chain, same depth as the strobe chain
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            auxDly_q <= '0;
        end else begin
            auxDly_q <= {auxDly_q[TAPS-2:0], link.calAux};
        end
    end

    assign strobeTaps = {strobeDly_q, link.calStrobe};
    assign auxTaps = {auxDly_q, link.calAux};

    // One select for the whole array
    assign calEdge = strobeTaps[link.fineDelay];
    assign calAuxD = auxTaps[link.fineDelay];

    // ==========================================================
    // Per-pixel enable memory
    // A write outside the array is dropped rather than wrapped,
    // since wrapping would silently enable the wrong pixel.
    logic [NPIX-1:0] calEn_q;             // One enable per pixel
    int wrIdx;                            // Linear write index
    logic wrInRange;                      // Write hits the array

    // Linear index and range check
    always_comb begin
        wrIdx = int'(link.pixRow) * COLS + int'(link.pixCol);
        wrInRange = (int'(link.pixRow) < ROWS) &&
            (int'(link.pixCol) < COLS);
    end

    // Enable bit storage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // All pixels start disabled
            calEn_q <= '0;
        end else if (link.pixWr && wrInRange) begin
            calEn_q[wrIdx] <= link.pixEn;
        end
    end

    // ==========================================================
    // Shared switch equations
    // The strobe net is one wire for every pixel, all of them see
    // it in the same cycle, well inside the STROBE_SKEW_NS window.
    logic eqOr;                           // strobe OR aux
    logic eqAndN;                         // NOT strobe AND aux

    assign eqOr = calEdge | calAuxD;
    assign eqAndN = ~calEdge & calAuxD;

    // ==========================================================
    // Previous switch levels for rise detection
    logic [NPIX-1:0] firstPrev_q;         // First switch last cycle
    logic [NPIX-1:0] secondPrev_q;        // Second switch last cycle

    // Switch history
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            firstPrev_q <= '0;
        end else begin
            firstPrev_q <= firstSw;
        end
    end

    // Second switch history
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            secondPrev_q <= '0;
        end else begin
            secondPrev_q <= secondSw;
        end
    end

    // ==========================================================
    // Per-pixel switch assignment
    // Parity is a constant of the pixel position, so the swap is
    // a plain mux with no clocked stage in the path.
    genvar r;
    genvar c;
    generate
        for (r = 0; r < ROWS; r++) begin : gRow
            for (c = 0; c < COLS; c++) begin : gCol
                // Position and parity of this pixel
                localparam int IDX = r * COLS + c;
                localparam logic ODD = 1'((r + c) % 2);
                logic swap;               // Odd pixel in alternating mode

                // Mode bit set means alternating; enable plays no part
                assign swap = link.altMode & ODD;

                // Uniform equations, swapped on odd pixels
                assign firstSw[IDX] = swap ? eqAndN : eqOr;
                assign secondSw[IDX] = swap ? eqOr : eqAndN;

                // Analog injection on any rise of an enabled pixel
                // A strobe rise lifts eqOr, a fall with aux high lifts
                // eqAndN, so the pair fires in that order and two
                // shots happen without re-priming.
                assign analogInject[IDX] = calEn_q[IDX] & ~link.digitalSel &
                    ((firstSw[IDX] & ~firstPrev_q[IDX]) |
                    (secondSw[IDX] & ~secondPrev_q[IDX]));

                // Digital injection passes the strobe to hit logic
                assign digitalHit[IDX] = calEn_q[IDX] & link.digitalSel &
                    calEdge;
            end
        end
    endgenerate
endmodule

//--- design/cal_cmd_ctrl.sv
// Command decoder end: calibration strobe and aux sequencer
module cal_cmd_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [cal_inj_pkg::ADDR_W-1:0] regAddr,
    input wire logic [cal_inj_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [cal_inj_pkg::DATA_W-1:0] regRdata,
    cal_link_if.ctrl link
);
    import cal_inj_pkg::*;

    // ==========================================================
    // Configuration registers
    logic digitalSel_q;                   // Injection type
    logic altMode_q;                      // Assignment mode
    logic [FINE_W-1:0] fineDelay_q;       // Fine phase select
    logic ctrlWr;                         // Control register write
    logic cmdWr;                          // Command register write
    logic pixWrReq;                       // Pixel enable write

    assign ctrlWr = regWr && (regAddr == REG_CTRL_OFS);
    assign cmdWr = regWr && (regAddr == REG_CMD_OFS);
    assign pixWrReq = regWr && (regAddr == REG_PIX_OFS);

    // Control register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            digitalSel_q <= 1'b0;
            altMode_q <= 1'b0;
            fineDelay_q <= '0;
        end else if (ctrlWr) begin
            digitalSel_q <= regWdata[CTRL_DIG_BIT];
            altMode_q <= regWdata[CTRL_ALT_BIT];
            fineDelay_q <= regWdata[CTRL_FINE_LSB +: FINE_W];
        end
    end

    // ==========================================================
    // Pixel enable write forwarding, one pulse per bus write
    logic pixWr_q;
    logic [ROW_W-1:0] pixRow_q;
    logic [COL_W-1:0] pixCol_q;
    logic pixEn_q;

    // Pulse and payload toward the array
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pixWr_q <= 1'b0;
            pixRow_q <= '0;
            pixCol_q <= '0;
            pixEn_q <= 1'b0;
        end else begin
            pixWr_q <= pixWrReq;
            if (pixWrReq) begin
                pixRow_q <= regWdata[PIX_ROW_LSB +: ROW_W];
                pixCol_q <= regWdata[PIX_COL_LSB +: COL_W];
                pixEn_q <= regWdata[PIX_EN_BIT];
            end
        end
    end

    // ==========================================================
    // Command sequencer
    // A command written while one runs is dropped; software polls
    // the busy bit, which keeps the sequencer free of queueing.
    seq_state_t state_q;
    logic [CNT_W-1:0] cnt_q;              // Cycles since start
    logic cmdPulse_q;                     // 1 = pulse, 0 = step
    logic [DLY_W-1:0] edgeDly_q;
    logic [DLY_W-1:0] dur_q;
    logic auxVal_q;
    logic [DLY_W-1:0] auxDly_q;
    logic strobe_q;
    logic aux_q;
    logic [CNT_W-1:0] edgeAt;             // Strobe rise count
    logic [CNT_W-1:0] offAt;              // Pulse fall count
    logic [CNT_W-1:0] auxAt;              // Aux update count
    logic [CNT_W-1:0] lastAt;             // Last event count

    // Event positions
    always_comb begin
        edgeAt = {1'b0, edgeDly_q};
        offAt = edgeAt + {1'b0, dur_q};
        auxAt = {1'b0, auxDly_q};
        lastAt = (offAt > auxAt) ? offAt : auxAt;
    end

    // State and counter
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= SEQ_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                SEQ_IDLE: begin
                    cnt_q <= '0;
                    if (cmdWr) begin
                        state_q <= SEQ_RUN;
                    end
                end
                SEQ_RUN: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q >= lastAt) begin
                        state_q <= SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    // Command fields, latched only when idle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmdPulse_q <= 1'b0;
            edgeDly_q <= '0;
            dur_q <= '0;
            auxVal_q <= 1'b0;
            auxDly_q <= '0;
        end else if (cmdWr && state_q == SEQ_IDLE) begin
            cmdPulse_q <= regWdata[CMD_MODE_BIT];
            edgeDly_q <= regWdata[CMD_EDLY_LSB +: DLY_W];
            dur_q <= regWdata[CMD_DUR_LSB +: DLY_W];
            auxVal_q <= regWdata[CMD_AUXV_BIT];
            auxDly_q <= regWdata[CMD_ADLY_LSB +: DLY_W];
        end
    end

    // Strobe: step only rises, pulse falls after the duration
    // With zero duration the fall wins, which is how priming works.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strobe_q <= 1'b0;
        end else if (state_q == SEQ_RUN) begin
            if (cmdPulse_q && cnt_q == offAt) begin
                strobe_q <= 1'b0;
            end else if (cnt_q == edgeAt) begin
                strobe_q <= 1'b1;
            end
        end
    end

    // Aux level takes the command value after its own delay
    // Software orders the aux delay after the strobe rise.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aux_q <= 1'b0;
        end else if (state_q == SEQ_RUN && cnt_q == auxAt) begin
            aux_q <= auxVal_q;
        end
    end

    // ==========================================================
    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regRdata <= REG_ZERO;
        end else begin
            regRdata <= REG_ZERO;
            if (regRd) begin
                unique case (regAddr)
                    REG_CTRL_OFS: begin
                        regRdata[CTRL_DIG_BIT] <= digitalSel_q;
                        regRdata[CTRL_ALT_BIT] <= altMode_q;
                        regRdata[CTRL_FINE_LSB +: FINE_W] <= fineDelay_q;
                    end
                    REG_STAT_OFS: begin
                        regRdata[STAT_BUSY_BIT] <= (state_q == SEQ_RUN);
                        regRdata[STAT_EDGE_BIT] <= strobe_q;
                        regRdata[STAT_AUX_BIT] <= aux_q;
                    end
                    // Unmapped and write-only offsets read zero
                    default: begin
                        regRdata <= REG_ZERO;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Link drive
    assign link.calStrobe = strobe_q;
    assign link.calAux = aux_q;
    assign link.digitalSel = digitalSel_q;
    assign link.altMode = altMode_q;
    assign link.fineDelay = fineDelay_q;
    assign link.pixWr = pixWr_q;
    assign link.pixRow = pixRow_q;
    assign link.pixCol = pixCol_q;
    assign link.pixEn = pixEn_q;
endmodule

//--- tb/cal_inj_properties.sv
// Checker for the calibration link and its two ends
module cal_inj_checker #(
    parameter int ROWS = cal_inj_pkg::PIX_ROWS,
    parameter int COLS = cal_inj_pkg::PIX_COLS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [cal_inj_pkg::ADDR_W-1:0] regAddr,
    input wire logic [cal_inj_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic calStrobe,
    input wire logic calAux,
    input wire logic digitalSel,
    input wire logic altMode,
    input wire logic [cal_inj_pkg::FINE_W-1:0] fineDelay,
    input wire logic pixWr,
    input wire logic [cal_inj_pkg::ROW_W-1:0] pixRow,
    input wire logic [cal_inj_pkg::COL_W-1:0] pixCol,
    input wire logic pixEn,
    input wire logic [ROWS*COLS-1:0] firstSw,
    input wire logic [ROWS*COLS-1:0] secondSw,
    input wire logic [ROWS*COLS-1:0] analogInject,
    input wire logic [ROWS*COLS-1:0] digitalHit
);
    import cal_inj_pkg::*;
    localparam int N = ROWS * COLS;
    // ==========================================================
    // Helpers
    // Odd pixels by coordinate sum
    function automatic logic [N-1:0] odd_mask();
        logic [N-1:0] m;
        for (int i = 0; i < N; i++) begin
            m[i] = 1'(((i / COLS) + (i % COLS)) % 2);
        end
        return m;
    endfunction
    localparam logic [N-1:0] ODD = odd_mask();
    wire [N-1:0] swOn = {N{calStrobe | calAux}};    // OR term
    wire [N-1:0] swOff = {N{~calStrobe & calAux}};  // AND-NOT term
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // ==========================================================
    // Command sequences; only issued while the link is idle
    sequence stepCmd;
        regWr && regAddr == REG_CMD_OFS && regWdata == 32'h6 && !calStrobe;
    endsequence
    sequence pulseCmd;
        regWr && regAddr == REG_CMD_OFS && regWdata == 32'h120805
            && !calStrobe && !calAux;
    endsequence
    sequence pulseHigh;
        (calStrobe && !calAux) [*2] ##1 (calStrobe && calAux) [*2];
    endsequence
    // ==========================================================
    // Properties
    AST_CTRL_WRITE: assert property (regWr && regAddr == REG_CTRL_OFS
        |=> digitalSel == $past(regWdata[0]) && altMode == $past(regWdata[1])
        && fineDelay == $past(regWdata[4:2]))
        else $error("control fields not forwarded");
    AST_PIX_WRITE: assert property (regWr && regAddr == REG_PIX_OFS
        |=> pixWr && pixEn == $past(regWdata[0])
        && pixCol == $past(regWdata[10:8]) && pixRow == $past(regWdata[18:16]))
        else $error("pixel enable write not forwarded");
    AST_UNIFORM: assert property (fineDelay == 0 && !altMode
        |-> firstSw == swOn && secondSw == swOff)
        else $error("uniform switch equations broken");
    AST_ALTERNATE: assert property (fineDelay == 0 && altMode
        |-> firstSw == ((swOn & ~ODD) | (swOff & ODD))
        && secondSw == ((swOff & ~ODD) | (swOn & ODD)))
        else $error("alternating switch equations broken");
    AST_INJECT_CAUSE: assert property ((analogInject
        & ~((firstSw & ~$past(firstSw)) | (secondSw & ~$past(secondSw))))
        == '0)
        else $error("injection without a switch rise");
    AST_KIND_SELECT: assert property (
        (digitalSel ? analogInject : digitalHit) == '0)
        else $error("wrong injection kind active");
    AST_FINE_ONE: assert property (fineDelay == 1 && !altMode
        && $past(fineDelay) == 1
        |-> firstSw == {N{$past(calStrobe) | $past(calAux)}})
        else $error("fine delay of one cycle not applied");
    AST_STEP_TIMING: assert property (stepCmd
        |=> !calStrobe [*4] ##1 calStrobe [*3])
        else $error("step strobe timing wrong");
    AST_DOUBLE_PULSE: assert property (pulseCmd
        |=> ##3 pulseHigh ##1 (!calStrobe && calAux))
        else $error("pulse strobe or aux timing wrong");
endmodule

//--- tb/tb_cal_injection_switch_control.sv
// Bench joining the command decoder to the pixel array
module tb_cal_injection_switch_control;
    timeunit 1ns;
    timeprecision 1ps;
    import cal_inj_pkg::*;
    localparam int N = PIX_ROWS * PIX_COLS;
    localparam logic [N-1:0] EN_MASK = 64'h203;  // Pixels 0, 1 and 9
    // ==========================================================
    // Signals
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic [N-1:0] firstSw, secondSw, analogInject, digitalHit;
    logic [N-1:0] injSeen;  // Pixels injected
    logic [7:0] injCnt0;    // Shots in pixel 0
    logic clrInj = 1'b1;    // Clears both tallies
    logic [N-1:0] oddMask;  // Expected odd pixels
    int fails = 0;
    int samplesChecked = 0;
    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // ==========================================================
    // Design ends and checker
    cal_link_if i_cal_link_if ();
    cal_cmd_ctrl i_cal_cmd_ctrl (.ref_clk(ref_clk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .link(i_cal_link_if.ctrl));
    cal_pixel_array #(.ROWS(PIX_ROWS), .COLS(PIX_COLS)) i_cal_pixel_array (
        .ref_clk(ref_clk), .rst(rst), .link(i_cal_link_if.pix),
        .firstSw(firstSw), .secondSw(secondSw),
        .analogInject(analogInject), .digitalHit(digitalHit));
    cal_inj_checker #(.ROWS(PIX_ROWS), .COLS(PIX_COLS)) i_cal_inj_checker (
        .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr),
        .calStrobe(i_cal_link_if.calStrobe),
        .calAux(i_cal_link_if.calAux), .digitalSel(i_cal_link_if.digitalSel),
        .altMode(i_cal_link_if.altMode), .fineDelay(i_cal_link_if.fineDelay),
        .pixWr(i_cal_link_if.pixWr), .pixRow(i_cal_link_if.pixRow),
        .pixCol(i_cal_link_if.pixCol), .pixEn(i_cal_link_if.pixEn),
        .firstSw(firstSw), .secondSw(secondSw),
        .analogInject(analogInject), .digitalHit(digitalHit));
    // Tally injection pulses; each lasts one cycle
    always @(posedge ref_clk) begin
        if (clrInj) begin
            injSeen <= '0;
            injCnt0 <= 8'h00;
        end else begin
            injSeen <= injSeen | analogInject;
            injCnt0 <= injCnt0 + 8'(analogInject[0]);
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [63:0] seen, exp, input string msg);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
    // Poll busy, then let the longest fine delay drain
    task automatic wait_idle();
        logic [31:0] d;
        d = 32'h1;
        for (int i = 0; i < 40 && d[STAT_BUSY_BIT] !== 1'b0; i++) begin
            rd(REG_STAT_OFS, d);
        end
        check(64'(d[STAT_BUSY_BIT]), 64'h0, "still busy");
        repeat (9) @(posedge ref_clk);
    endtask
    // Strobe and aux low, with settling time after
    task automatic prime();
        wr(REG_CMD_OFS, 32'h1);
        wait_idle();
    endtask
    task automatic start(input logic [31:0] ctrl);
        wr(REG_CTRL_OFS, ctrl);
        prime();
        @(posedge ref_clk);
        clrInj <= 1'b1;
        @(posedge ref_clk);
        clrInj <= 1'b0;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_registers();
        logic [31:0] d;
        check(firstSw | secondSw, 64'h0, "switches set after reset");
        wr(REG_CTRL_OFS, 32'h1F);
        rd(REG_CTRL_OFS, d);
        check(d, 32'h1F, "control read back");
        wr(REG_STAT_OFS, 32'hFFFFFFFF);
        rd(REG_STAT_OFS, d);
        check(d, 32'h0, "status idle");
        rd(8'h10, d);
        check(d, 32'h0, "unmapped read");
        wr(REG_PIX_OFS, 32'h1);
        wr(REG_PIX_OFS, 32'h101);
        wr(REG_PIX_OFS, 32'h10101);
        $display("registers test done");
    endtask
    // Single step; second switch stays low in uniform mode
    task automatic t_single(input logic alt);
        start({30'h0, alt, 1'b0});
        wr(REG_CMD_OFS, 32'h6);
        wait_idle();
        check(firstSw, alt ? ~oddMask : {N{1'b1}}, "first switch");
        check(secondSw, alt ? oddMask : {N{1'b0}}, "second switch");
        check(injSeen, EN_MASK, "injected pixels");
        $display("single test done");
    endtask
    task automatic t_double();
        start(32'h0);
        wr(REG_CMD_OFS, 32'h120805);
        wait_idle();
        check(64'(injCnt0), 64'h2, "double count");
        check(injSeen, EN_MASK, "double pixels");
        check(firstSw & secondSw, {N{1'b1}}, "both switches thrown");
        prime();
        check(firstSw | secondSw, 64'h0, "aux not returned low");
        $display("double test done");
    endtask
    task automatic t_digital();
        start(32'h1);
        wr(REG_CMD_OFS, 32'h6);
        wait_idle();
        check(digitalHit, EN_MASK, "digital hits");
        check(injSeen, 64'h0, "analog during digital");
        prime();
        check(digitalHit, 64'h0, "hit after strobe low");
        $display("digital test done");
    endtask
    task automatic t_fine();
        int ts = -1;
        int tf = -1;
        start(32'h4);
        wr(REG_CMD_OFS, 32'h6);
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            #1;
            if (ts < 0 && i_cal_link_if.calStrobe === 1'b1) ts = i;
            if (tf < 0 && firstSw[0] === 1'b1) tf = i;
        end
        check(64'(tf - ts), 64'h1, "fine delay offset");
        wait_idle();
        check(firstSw, {N{1'b1}}, "switches not together");
        $display("fine delay test done");
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        for (int i = 0; i < N; i++) begin
            oddMask[i] = 1'(((i / PIX_COLS) + (i % PIX_COLS)) % 2);
        end
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        clrInj <= 1'b0;
        @(posedge ref_clk);
        t_registers();
        t_single(1'b0);
        t_single(1'b1);
        t_double();
        t_digital();
        t_fine();
        conclude();
    end
    initial begin
        #100us;
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
